// file: rtl/cal_current_trigger_control.sv
// calibration gate, current level control and trigger arming
// assumes a register port master, pins from outside the clock domain,
// and a list sequencer on the same clock offering list levels
// Operation
// - cal commands other than auto-cal and the mode switch refused unless cal mode on
// - new password committed to nv at once
// - zero password lets cal mode open freely
// - password starts as the model number
// - save copies working constants into nv
// - nonzero password needs match, else error
// - cal mode query returns only 0 or 1
// - leaving cal mode drops unsaved constants
// - two points give constants held until saved
// - ov cal runs alone, stores in nv
// - immediate level write always reaches output
// - fixed mode blocks list, list mode allows
// - selecting list mode also cancels triggers
// - oc protect plus cc regulation trips output
// - oc latch cleared only by protection clear
// - pending level kept apart, applied on trigger
// - pending read without value gives immediate
// - unarmed trigger events and commands ignored
// - initiate arms for one trigger action
// - continuous arm keeps subsystem always armed
// - display enable switches readouts only
`timescale 1ns/100ps
module cal_current_trigger_control #(
  parameter int          OV_CYCLES    = pm_ctrl_pkg::OV_CAL_CYCLES,
  parameter logic [15:0] MODEL_NUMBER = 16'h1234 // arbitrary value
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire pm_ctrl_pkg::bus_req_type  bus_req,
  output      logic [31:0]               rdata,
  input  wire logic                      trigger_pin,
  input  wire logic                      cc_pin,
  input  wire logic                      cv_pin,
  input  wire logic                      output_request,
  input  wire logic [15:0]               list_level,
  input  wire logic                      list_valid,
  input  wire logic [31:0]               ov_sense,
  output      pm_ctrl_pkg::ctrl_out_type ctrl_out,
  output      logic                      list_abort,
  output      logic                      auto_cal_pulse,
  output      logic                      error_pulse
);
  import pm_ctrl_pkg::*;
  generate
    if (OV_CYCLES < 2) begin : g_bad
      $error("ov calibration count too small");
    end
  endgenerate
  logic [4:0]  a;
  logic [31:0] wd;
  logic        wr;
  logic        w_state, w_pass, w_save, w_ovc, w_imm, w_mode, w_ocp;
  logic        w_pend, w_pclr, w_init, w_cont, w_abort, w_trig, w_disp;
  logic [1:0]  w_sel, w_val, seq_err, dirty;
  logic        cal_gated, locked, cal_en, pass_ok, cal_off_evt;
  logic [2:0]  pin_s1, pin_s2, pin_s3, pin_st;
  logic        trig_prev, trig_rise, trig_fire, armed, cont, next_cont;
  logic        abort, list_mode, ocp, oc, oc_set, out_on, display;
  logic [15:0] imm, pend;
  logic        pend_v, ov_busy, ov_start, ov_bad, ov_done;
  logic [31:0] ov_count;
  logic [7:0]  err_code, next_err;
  logic [NV_WORDS-1:0]    nv_wr_mask;
  logic [NV_WORDS*32-1:0] nv_wr_data, nv_q;
  logic [31:0] work [2];
  logic [31:0] eff [2];
  logic [31:0] nv_pass;
  // command decode from the register port
  assign a  = bus_req.addr;
  assign wd = bus_req.wdata;
  assign wr = bus_req.wr;
  assign w_state  = wr && a == OFF_CAL_STATE;
  assign w_pass   = wr && a == OFF_CAL_PASS;
  assign w_save   = wr && a == OFF_CAL_SAVE;
  assign w_ovc    = wr && a == OFF_OV_CAL;
  assign w_sel[0] = wr && a == OFF_VPOINT_SEL;
  assign w_val[0] = wr && a == OFF_VVALUE;
  assign w_sel[1] = wr && a == OFF_CPOINT_SEL;
  assign w_val[1] = wr && a == OFF_CVALUE;
  assign w_imm    = wr && a == OFF_IMMEDIATE_CURRENT_LEVEL_IMM;
  assign w_mode   = wr && a == OFF_CURRENT_MODE_SELECT;
  assign w_ocp    = wr && a == OFF_OC_PROT;
  assign w_pend   = wr && a == OFF_IMMEDIATE_CURRENT_LEVEL_PEND;
  assign w_pclr   = wr && a == OFF_PROT_CLEAR;
  assign w_init   = wr && a == OFF_INIT;
  assign w_cont   = wr && a == OFF_CONT_ARM;
  assign w_abort  = wr && a == OFF_TRIG_CANCEL;
  assign w_trig   = wr && a == OFF_BUS_TRIG;
  assign w_disp   = wr && a == OFF_DISPLAY;
  // cal commands other than auto-cal and the mode switch are gated
  assign cal_gated = w_pass | w_save | w_ovc | (|w_sel) | (|w_val);
  assign locked    = cal_gated & ~cal_en;
  // pin synchronisers, a level counts once stages two and three agree
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        pin_s1[i] <= 1'b0;
        pin_s2[i] <= 1'b0;
        pin_s3[i] <= 1'b0;
        pin_st[i] <= 1'b0;
      end else begin
        pin_s1[i] <= (i == 2) ? trigger_pin : (i == 1) ? cc_pin : cv_pin;
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
        if (pin_s2[i] == pin_s3[i]) pin_st[i] <= pin_s3[i];
      end
    end
  end
  // cal mode switch with password check
  assign nv_pass = nv_q[NV_PASS*32 +: 32];
  assign pass_ok = (nv_pass == 32'h0) ||
                   (wd[POS_PASS_GIVEN] &&
                    wd[POS_PASS_LSB +: 16] == nv_pass[15:0]);
  assign cal_off_evt = w_state && !wd[POS_ENABLE] && cal_en;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cal_en <= 1'b0;
    end else if (w_state) begin
      if (!wd[POS_ENABLE]) cal_en <= 1'b0;
      else if (pass_ok) cal_en <= 1'b1;
    end
  end
  // two-point calibration per channel, 0 voltage, 1 current
  for (genvar c = 0; c < 2; c++) begin : g_cal
    point_state_type pstate;
    logic [15:0]     low_val;
    assign eff[c] = dirty[c] ? work[c] : nv_q[(c + 1)*32 +: 32];
    always_comb begin
      seq_err[c] = 1'b0;
      if (cal_en && w_sel[c] && wd[0] && pstate != PT_LOW_IN) seq_err[c] = 1'b1;
      if (cal_en && w_val[c] && pstate != PT_LOW_SEL && pstate != PT_HIGH_SEL)
        seq_err[c] = 1'b1;
    end
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        pstate   <= PT_IDLE;
        low_val  <= 16'h0;
        work[c]  <= 32'h0;
        dirty[c] <= 1'b0;
      end else if (cal_off_evt) begin
        pstate   <= PT_IDLE;
        dirty[c] <= 1'b0;
      end else if (w_save && cal_en) begin
        dirty[c] <= 1'b0;
      end else if (cal_en && w_sel[c]) begin
        if (!wd[0]) pstate <= PT_LOW_SEL;
        else if (pstate == PT_LOW_IN) pstate <= PT_HIGH_SEL;
        else pstate <= PT_IDLE;
      end else if (cal_en && w_val[c]) begin
        unique case (pstate)
          PT_LOW_SEL: begin
            low_val <= wd[15:0];
            pstate  <= PT_LOW_IN;
          end
          PT_HIGH_SEL: begin
            work[c]  <= {wd[15:0] - low_val, low_val};
            dirty[c] <= 1'b1;
            pstate   <= PT_IDLE;
          end
          default: pstate <= PT_IDLE;
        endcase
      end
    end
  end
  // ov calibration runs on its own for a long fixed time
  assign ov_bad   = w_ovc && cal_en && (ov_busy || !out_on || !pin_st[0]);
  assign ov_start = w_ovc && cal_en && !ov_bad;
  assign ov_done  = ov_busy && ov_count == 32'd1;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ov_busy  <= 1'b0;
      ov_count <= 32'h0;
    end else if (ov_start) begin
      ov_busy  <= 1'b1;
      ov_count <= 32'(OV_CYCLES);
    end else if (ov_busy) begin
      ov_count <= ov_count - 32'd1;
      if (ov_done) ov_busy <= 1'b0;
    end
  end
  // nonvolatile commits: password, saved constants, ov constant
  always_comb begin
    nv_wr_mask = '0;
    nv_wr_mask[NV_PASS] = w_pass && cal_en;
    nv_wr_mask[NV_VOLT] = w_save && cal_en;
    nv_wr_mask[NV_IMMEDIATE_CURRENT_LEVEL] = w_save && cal_en;
    nv_wr_mask[NV_OV]   = ov_done;
  end
  assign nv_wr_data = {ov_sense, eff[1], eff[0], 16'h0, wd[15:0]};
  pm_nv_store #(
    .NWORDS (NV_WORDS),
    .W      (32),
    .INIT   ({96'h0, 16'h0, MODEL_NUMBER})
  ) u_nv (
    .clk     (clk),
    .reset_n (reset_n),
    .wr_mask (nv_wr_mask),
    .wr_data (nv_wr_data),
    .q       (nv_q)
  );
  // trigger arming
  assign trig_rise = pin_st[2] && !trig_prev;
  assign trig_fire = armed && (w_trig || trig_rise);
  assign abort     = w_abort || (w_mode && wd[0]);
  assign next_cont = w_cont ? wd[0] : cont;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trig_prev <= 1'b0;
      cont      <= 1'b0;
      armed     <= 1'b0;
    end else begin
      trig_prev <= pin_st[2];
      cont      <= next_cont;
      if (next_cont) armed <= 1'b1;
      else if (abort) armed <= 1'b0;
      else if (w_init) armed <= 1'b1;
      else if (trig_fire) armed <= 1'b0;
    end
  end
  // immediate and pending current levels
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      imm    <= IMMEDIATE_CURRENT_LEVEL_RST;
      pend   <= IMMEDIATE_CURRENT_LEVEL_RST;
      pend_v <= 1'b0;
    end else begin
      if (w_imm) imm <= wd[15:0];
      else if (trig_fire && pend_v) imm <= pend;
      else if (list_mode && list_valid) imm <= list_level;
      if (w_pend) begin
        pend   <= wd[15:0];
        pend_v <= 1'b1;
      end else if (trig_fire || abort) begin
        pend_v <= 1'b0;
      end
    end
  end
  // mode, protection and display settings
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      list_mode  <= 1'b0;
      ocp        <= 1'b0;
      display    <= DISPLAY_RST;
      list_abort <= 1'b0;
    end else begin
      if (w_mode) list_mode <= wd[0];
      if (w_ocp) ocp <= wd[0];
      if (w_disp) display <= wd[0];
      list_abort <= abort;
    end
  end
  // overcurrent latch, the trip wins over a clear in the same cycle
  assign oc_set = ocp && pin_st[1];
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oc     <= 1'b0;
      out_on <= 1'b0;
    end else begin
      if (oc_set) oc <= 1'b1;
      else if (w_pclr) oc <= 1'b0;
      out_on <= output_request && !(oc || oc_set);
    end
  end
  // error code, a new error wins over the clearing read
  always_comb begin
    next_err = ERR_NONE;
    if (locked) next_err = ERR_CAL_LOCKED;
    else if (w_state && wd[POS_ENABLE] && !pass_ok) next_err = ERR_PASSWORD;
    else if (|seq_err) next_err = ERR_SEQUENCE;
    else if (ov_bad) next_err = ERR_OV_COND;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      err_code       <= ERR_NONE;
      error_pulse    <= 1'b0;
      auto_cal_pulse <= 1'b0;
    end else begin
      if (next_err != ERR_NONE) err_code <= next_err;
      else if (bus_req.rd && a == OFF_ERROR) err_code <= ERR_NONE;
      error_pulse    <= next_err != ERR_NONE;
      auto_cal_pulse <= wr && a == OFF_AUTO_CAL;
    end
  end
  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!reset_n || !bus_req.rd) begin
      rdata <= 32'h0;
    end else begin
      unique case (a)
        OFF_CAL_STATE:  rdata <= {31'h0, cal_en};
        OFF_IMMEDIATE_CURRENT_LEVEL_IMM:   rdata <= {16'h0, imm};
        OFF_IMMEDIATE_CURRENT_LEVEL_PEND:  rdata <= {16'h0, pend_v ? pend : imm};
        OFF_CURRENT_MODE_SELECT:  rdata <= {31'h0, list_mode};
        OFF_OC_PROT:    rdata <= {31'h0, ocp};
        OFF_CONT_ARM:   rdata <= {31'h0, cont};
        OFF_DISPLAY:    rdata <= {31'h0, display};
        OFF_ERROR:      rdata <= {24'h0, err_code};
        OFF_STATUS:     rdata <= {24'h0, out_on, ov_busy, pend_v, oc,
                                  list_mode, cont, armed, cal_en};
        default:        rdata <= 32'h0;
      endcase
    end
  end
  // outputs from registers
  assign ctrl_out.level           = imm;
  assign ctrl_out.output_on       = out_on;
  assign ctrl_out.display_on      = display;
  assign ctrl_out.overcurrent_bit = oc;
  assign ctrl_out.volt_cal        = eff[0];
  assign ctrl_out.immediate_current_level_cal        = eff[1];
  assign ctrl_out.ov_cal          = nv_q[NV_OV*32 +: 32];
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_locked_reject: assert property (
    locked |-> nv_wr_mask == '0 ##1 err_code == ERR_CAL_LOCKED)
    else $error("locked cal command had an effect");
  chk_pass_commit: assert property (
    w_pass && cal_en |=> nv_pass[15:0] == $past(wd[15:0]))
    else $error("password not committed");
  chk_zero_pass: assert property (
    w_state && wd[POS_ENABLE] && nv_pass == 32'h0 |=> cal_en)
    else $error("zero password did not open cal mode");
  chk_bad_pass: assert property (
    w_state && wd[POS_ENABLE] && !cal_en && !pass_ok
      |=> !cal_en && err_code == ERR_PASSWORD)
    else $error("wrong password accepted");
  chk_cal_query: assert property (
    bus_req.rd && a == OFF_CAL_STATE |=> rdata == {31'h0, $past(cal_en)})
    else $error("cal query wrong");
  chk_discard_unsaved: assert property (
    cal_off_evt |=> dirty == 2'b00)
    else $error("unsaved constants kept");
  chk_imm_write: assert property (
    w_imm |=> ctrl_out.level == $past(wd[15:0]))
    else $error("immediate level not applied");
  chk_fixed_mode: assert property (
    !list_mode && !w_imm && !trig_fire |=> $stable(imm))
    else $error("level moved in fixed mode");
  chk_list_abort: assert property (
    w_mode && wd[0] |=> !pend_v && list_abort)
    else $error("list select did not cancel");
  chk_oc_trip: assert property (
    oc_set |=> oc && !out_on)
    else $error("overcurrent did not trip");
  chk_oc_hold: assert property (
    oc && !w_pclr |=> oc)
    else $error("oc latch dropped without clear");
  chk_unarmed_hold: assert property (
    !armed && pend_v && !abort |=> pend_v)
    else $error("unarmed trigger consumed pending level");
  chk_single_arm: assert property (
    trig_fire && !next_cont |=> !armed)
    else $error("still armed after single trigger");
  chk_cont_arm: assert property (
    cont && !w_cont ##1 1'b1 |-> armed)
    else $error("continuous arm lost");
  cov_trigger_apply: cover property (trig_fire && pend_v);
  cov_cal_done: cover property (w_val[1] && dirty[1] == 1'b0 ##1 dirty[1]);
  cov_oc_trip: cover property (oc_set ##[1:20] w_pclr);
  cov_ov_run: cover property (ov_start);
endmodule : cal_current_trigger_control

// file: rtl/pm_ctrl_pkg.sv
// shared constants and carrier types for the power module command logic
// assumes one 50 MHz clock domain and a plain register port master
package pm_ctrl_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int LVL_W  = 16;
  localparam int NV_WORDS = 4;

  // register offsets, a write to a command offset is that command
  localparam logic [4:0] OFF_CAL_STATE  = 5'h00;
  localparam logic [4:0] OFF_CAL_PASS   = 5'h01;
  localparam logic [4:0] OFF_CAL_SAVE   = 5'h02;
  localparam logic [4:0] OFF_VPOINT_SEL = 5'h03;
  localparam logic [4:0] OFF_VVALUE     = 5'h04;
  localparam logic [4:0] OFF_CPOINT_SEL = 5'h05;
  localparam logic [4:0] OFF_CVALUE     = 5'h06;
  localparam logic [4:0] OFF_OV_CAL     = 5'h07;
  localparam logic [4:0] OFF_IMMEDIATE_CURRENT_LEVEL_IMM   = 5'h08;
  localparam logic [4:0] OFF_CURRENT_MODE_SELECT  = 5'h09;
  localparam logic [4:0] OFF_OC_PROT    = 5'h0a;
  localparam logic [4:0] OFF_IMMEDIATE_CURRENT_LEVEL_PEND  = 5'h0b;
  localparam logic [4:0] OFF_PROT_CLEAR = 5'h0c;
  localparam logic [4:0] OFF_INIT       = 5'h0d;
  localparam logic [4:0] OFF_CONT_ARM   = 5'h0e;
  localparam logic [4:0] OFF_TRIG_CANCEL = 5'h0f;
  localparam logic [4:0] OFF_BUS_TRIG   = 5'h10;
  localparam logic [4:0] OFF_DISPLAY    = 5'h11;
  localparam logic [4:0] OFF_AUTO_CAL   = 5'h12;
  localparam logic [4:0] OFF_STATUS     = 5'h13;
  localparam logic [4:0] OFF_ERROR      = 5'h14;

  // field positions
  localparam int POS_ENABLE    = 0;
  localparam int POS_PASS_GIVEN = 1;
  localparam int POS_PASS_LSB  = 16;
  localparam int ST_CAL_EN  = 0;
  localparam int ST_ARMED   = 1;
  localparam int ST_CONT    = 2;
  localparam int ST_LIST    = 3;
  localparam int ST_OC      = 4;
  localparam int ST_PEND_V  = 5;
  localparam int ST_OV_BUSY = 6;
  localparam int ST_OUT_ON  = 7;

  // nonvolatile word indices
  localparam int NV_PASS = 0;
  localparam int NV_VOLT = 1;
  localparam int NV_IMMEDIATE_CURRENT_LEVEL = 2;
  localparam int NV_OV   = 3;

  // error codes
  localparam logic [7:0] ERR_NONE       = 8'h00;
  localparam logic [7:0] ERR_CAL_LOCKED = 8'h01;
  localparam logic [7:0] ERR_PASSWORD   = 8'h02;
  localparam logic [7:0] ERR_SEQUENCE   = 8'h03;
  localparam logic [7:0] ERR_OV_COND    = 8'h04;

  // reset values and timing
  localparam logic [15:0] IMMEDIATE_CURRENT_LEVEL_RST    = 16'h0000;
  localparam logic        DISPLAY_RST = 1'b1;
  localparam int CLK_HZ    = 50_000_000;
  localparam int OV_CAL_MS = 2000;
  localparam int OV_CAL_CYCLES = OV_CAL_MS * (CLK_HZ / 1000);

  typedef enum logic [3:0] {
    PT_IDLE     = 4'b0001,
    PT_LOW_SEL  = 4'b0010,
    PT_LOW_IN   = 4'b0100,
    PT_HIGH_SEL = 4'b1000
  } point_state_type;

  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    logic [15:0] level;
    logic        output_on;
    logic        display_on;
    logic        overcurrent_bit;
    logic [31:0] volt_cal;
    logic [31:0] immediate_current_level_cal;
    logic [31:0] ov_cal;
  } ctrl_out_type;
endpackage : pm_ctrl_pkg

// file: rtl/pm_nv_store.sv
// nonvolatile word store: password and calibration constants
// assumes the owner raises one write bit per word it commits
`timescale 1ns/100ps
module pm_nv_store #(
  parameter int                    NWORDS = 4,
  parameter int                    W      = 32,
  parameter logic [NWORDS*W-1:0]   INIT   = '0
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic [NWORDS-1:0]   wr_mask,
  input  wire logic [NWORDS*W-1:0] wr_data,
  output      logic [NWORDS*W-1:0] q
);
  generate
    if (NWORDS < 1 || W < 1) begin : g_bad
      $error("nv store needs at least one word");
    end
  endgenerate

  // one register per word, read data straight from the register
  for (genvar i = 0; i < NWORDS; i++) begin : g_word
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        q[i*W +: W] <= INIT[i*W +: W];
      end else if (wr_mask[i]) begin
        q[i*W +: W] <= wr_data[i*W +: W];
      end
    end
  end
endmodule : pm_nv_store

// file: sim/host_model.sv
// host side command master for the power module register port
// assumes the bench calls its tasks from a single process
`timescale 1ns/100ps
module host_model (
  input  wire logic                     clk,
  output      pm_ctrl_pkg::bus_req_type bus_req,
  input  wire logic [31:0]              rdata
);
  import pm_ctrl_pkg::*;

  // idle bus until the first command
  initial bus_req = '0;

  // one write strobe cycle, then the bus goes idle
  task automatic wr(input logic [4:0] addr, input logic [31:0] data);
    @(posedge clk);
    bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
    #1;
  endtask : wr

  // one read strobe cycle, data taken in the following cycle
  task automatic rd(input logic [4:0] addr, output logic [31:0] data);
    @(posedge clk);
    bus_req <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    data = rdata;
  endtask : rd

  // two point calibration, low end always selected and entered first
  task automatic cal_point(input logic [4:0] sel, input logic [15:0] lo, input logic [15:0] hi);
    wr(sel, 32'h0);
    wr(sel + 5'h01, {16'h0, lo});
    wr(sel, 32'h1);
    wr(sel + 5'h01, {16'h0, hi});
  endtask : cal_point
endmodule : host_model

// file: sim/testbench.sv
// self-checking bench for the calibration, current and trigger logic
// assumes the host model drives the register port, the bench the pins
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin \
  n_compared++; \
  if (32'(got) !== 32'(exp)) begin \
    error_cnt++; \
    $display("[ERR] %0t %s", $time, msg); \
  end \
end
module testbench;
  import pm_ctrl_pkg::*;
  localparam logic [15:0] MODEL = 16'h4d2b; // arbitrary value
  logic         clk = 0, reset_n = 0, trigger_pin = 0, cc_pin = 0, cv_pin = 0;
  logic         output_request = 0, list_valid = 0, list_abort, auto_cal_pulse, error_pulse;
  logic [15:0]  list_level = '0, lo, hi, v;
  logic [31:0]  ov_sense = '0, rdata, d;
  bus_req_type  bus_req;
  ctrl_out_type ctrl_out;
  int           error_cnt = 0, n_compared = 0, cyc = 0, aborts = 0, autos = 0, errs = 0;
  int           exp_level = 0, exp_pend = 0;
  bit           pend_v = 0, armed = 0, cont = 0;

  host_model i_host_model (.clk(clk), .bus_req(bus_req), .rdata(rdata));
  cal_current_trigger_control #(.OV_CYCLES(8), .MODEL_NUMBER(MODEL))
    i_cal_current_trigger_control (
    .clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata), .trigger_pin(trigger_pin),
    .cc_pin(cc_pin), .cv_pin(cv_pin), .output_request(output_request), .list_level(list_level),
    .list_valid(list_valid), .ov_sense(ov_sense), .ctrl_out(ctrl_out), .list_abort(list_abort),
    .auto_cal_pulse(auto_cal_pulse), .error_pulse(error_pulse));

  // clock, pulse counters and hang limit
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    aborts += list_abort;
    autos += auto_cal_pulse;
    errs += error_pulse;
    if (cyc == 8000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk

  // trigger action in the reference model
  task automatic fire;
    if (armed) begin
      if (pend_v) exp_level = exp_pend;
      pend_v = 0;
      armed = cont;
    end
  endtask : fire

  // write, update the reference model, compare the output level
  task automatic wrc(input logic [4:0] a, input logic [31:0] dw);
    i_host_model.wr(a, dw);
    case (a)
      OFF_IMMEDIATE_CURRENT_LEVEL_IMM: exp_level = dw[15:0];
      OFF_IMMEDIATE_CURRENT_LEVEL_PEND: begin
        exp_pend = dw[15:0];
        pend_v = 1;
      end
      OFF_INIT: armed = 1;
      OFF_CONT_ARM: begin
        cont = dw[0];
        armed = armed | dw[0];
      end
      OFF_TRIG_CANCEL, OFF_CURRENT_MODE_SELECT: if (a == OFF_TRIG_CANCEL || dw[0]) begin
        pend_v = 0;
        armed = cont;
      end
      OFF_BUS_TRIG: fire();
      default: ;
    endcase
    `CHK(ctrl_out.level, exp_level, "output level")
  endtask : wrc

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    i_host_model.rd(a, d);
    `CHK(d, e, "read data")
  endtask : rdc

  // external trigger edge through the pin synchroniser
  task automatic pin_trig;
    @(posedge clk) trigger_pin <= 1'b1;
    tk(8);
    @(posedge clk) trigger_pin <= 1'b0;
    tk(6);
    fire();
    `CHK(ctrl_out.level, exp_level, "pin trigger level")
  endtask : pin_trig

  // main sequence
  initial begin
    void'($urandom(24694));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    tk(1);
    `CHK(ctrl_out.display_on, 1, "display reset")
    rdc(5'h1f, 32'h0);
    $display("test reset done");
    wrc(OFF_CAL_PASS, 32'h0);
    rdc(OFF_ERROR, 32'h1);
    wrc(OFF_CAL_STATE, 32'h1111_0003);
    rdc(OFF_ERROR, 32'h2);
    rdc(OFF_CAL_STATE, 32'h0);
    wrc(OFF_CAL_STATE, {MODEL, 16'h0003});
    rdc(OFF_CAL_STATE, 32'h1);
    wrc(OFF_VPOINT_SEL, 32'h1);
    rdc(OFF_ERROR, 32'h3);
    lo = 16'($urandom_range(16'h7fff));
    hi = lo + 16'($urandom_range(16'h7fff, 1));
    i_host_model.cal_point(OFF_VPOINT_SEL, lo, hi);
    `CHK(ctrl_out.volt_cal, {16'(hi - lo), lo}, "volt constants")
    wrc(OFF_CAL_STATE, 32'h0);
    `CHK(ctrl_out.volt_cal, 0, "unsaved dropped")
    wrc(OFF_CAL_STATE, {MODEL, 16'h0003});
    i_host_model.cal_point(OFF_CPOINT_SEL, lo, hi);
    wrc(OFF_CAL_SAVE, 32'h0);
    wrc(OFF_CAL_PASS, 32'h0);
    wrc(OFF_CAL_STATE, 32'h0);
    `CHK(ctrl_out.immediate_current_level_cal, {16'(hi - lo), lo}, "saved constants")
    wrc(OFF_CAL_STATE, 32'h1);
    rdc(OFF_CAL_STATE, 32'h1);
    $display("test calibration done");
    @(posedge clk) output_request <= 1'b1;
    ov_sense <= $urandom;
    tk(4);
    wrc(OFF_OV_CAL, 32'h0);
    rdc(OFF_ERROR, 32'h4);
    @(posedge clk) cv_pin <= 1'b1;
    tk(6);
    wrc(OFF_OV_CAL, 32'h0);
    tk(20);
    `CHK(ctrl_out.ov_cal, ov_sense, "ov constant")
    wrc(OFF_CAL_STATE, 32'h0);
    $display("test ov calibration done");
    wrc(OFF_IMMEDIATE_CURRENT_LEVEL_IMM, $urandom);
    rdc(OFF_IMMEDIATE_CURRENT_LEVEL_PEND, exp_level);
    @(posedge clk) list_level <= ~16'(exp_level);
    list_valid <= 1'b1;
    tk(3);
    `CHK(ctrl_out.level, exp_level, "fixed mode")
    wrc(OFF_CURRENT_MODE_SELECT, 32'h1);
    tk(2);
    exp_level = list_level;
    `CHK(ctrl_out.level, exp_level, "list mode")
    @(posedge clk) list_valid <= 1'b0;
    wrc(OFF_IMMEDIATE_CURRENT_LEVEL_IMM, $urandom);
    wrc(OFF_CURRENT_MODE_SELECT, 32'h0);
    $display("test current mode done");
    wrc(OFF_IMMEDIATE_CURRENT_LEVEL_PEND, $urandom);
    wrc(OFF_BUS_TRIG, 32'h0);
    wrc(OFF_INIT, 32'h0);
    wrc(OFF_IMMEDIATE_CURRENT_LEVEL_IMM, $urandom);
    wrc(OFF_BUS_TRIG, 32'h0);
    wrc(OFF_IMMEDIATE_CURRENT_LEVEL_PEND, $urandom);
    wrc(OFF_BUS_TRIG, 32'h0);
    wrc(OFF_TRIG_CANCEL, 32'h0);
    rdc(OFF_IMMEDIATE_CURRENT_LEVEL_PEND, exp_level);
    wrc(OFF_CONT_ARM, 32'h1);
    repeat (2) begin
      wrc(OFF_IMMEDIATE_CURRENT_LEVEL_PEND, $urandom);
      pin_trig();
    end
    wrc(OFF_INIT, 32'h0);
    wrc(OFF_CONT_ARM, 32'h0);
    repeat (2) begin
      wrc(OFF_IMMEDIATE_CURRENT_LEVEL_PEND, $urandom);
      pin_trig();
    end
    `CHK(aborts, 2, "abort pulses")
    $display("test trigger done");
    wrc(OFF_OC_PROT, 32'h1);
    @(posedge clk) cc_pin <= 1'b1;
    tk(8);
    `CHK({ctrl_out.overcurrent_bit, ctrl_out.output_on}, 2'b10, "oc trip")
    @(posedge clk) cc_pin <= 1'b0;
    tk(8);
    `CHK(ctrl_out.overcurrent_bit, 1, "oc latched")
    wrc(OFF_PROT_CLEAR, 32'h0);
    tk(2);
    `CHK({ctrl_out.overcurrent_bit, ctrl_out.output_on}, 2'b01, "oc cleared")
    rdc(OFF_STATUS, {24'h0, 2'b10, pend_v, 2'b00, cont, armed, 1'b0});
    wrc(OFF_DISPLAY, 32'h0);
    `CHK({ctrl_out.display_on, ctrl_out.output_on}, 2'b01, "display off")
    rdc(OFF_DISPLAY, 32'h0);
    wrc(OFF_AUTO_CAL, 32'h1);
    tk(2);
    `CHK(autos, 1, "auto cal pulse")
    `CHK(errs, 4, "error pulses")
    $display("test protection done");
    summarize();
  end
endmodule : testbench
